// ===== tbd_top.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module tbd_top #(
  parameter int AW = 12,
  parameter int W  = tbd_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write address
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // axi4-lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // clock logic
  input  wire logic          prescale_double_sel,
  // events and pins
  output logic               periodic_tick_irq,
  output logic               buzzer_out_pin
);
  import tbd_pkg::*;

  // mask of stages below and including the tap for a divide by 2^(exp+dbl)
  function automatic logic [W-1:0] tap_mask(input logic [4:0] exp, input logic dbl);
    logic [5:0] e;
    e = {1'b0, exp} + {5'h00, dbl}; // [RULE_15]
    tap_mask = W'((33'h1 << e) - 33'h1);
  endfunction : tap_mask

  logic [W-1:0]  count;
  logic [7:0]    ctrl_ff;
  logic [7:0]    nxt_ctrl;
  logic          aw_got_ff;
  logic          w_got_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0]   wdata_ff;
  logic [3:0]    wstrb_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          rvalid_ff;
  logic [31:0]   rdata_ff;
  logic [1:0]    rresp_ff;
  logic          irq_ff;
  logic          buz_ff;

  tbd_prescaler #(
    .W       (W)
  ) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .count   (count)
  );

  // write channel
  wire           aw_hs   = s_axi_awvalid & s_axi_awready;
  wire           w_hs    = s_axi_wvalid & s_axi_wready;
  wire           aw_have = aw_got_ff | aw_hs;
  wire           w_have  = w_got_ff | w_hs;
  wire           do_wr   = aw_have & w_have;
  wire [AW-1:0]  wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [31:0]    wr_data = w_hs ? s_axi_wdata : wdata_ff;
  wire [3:0]     wr_strb = w_hs ? s_axi_wstrb : wstrb_ff;
  wire           wr_hit  = (wr_addr[AW-1:2] == CTRL_ADDR[AW-1:2]);
  wire           wr_take = do_wr & wr_hit & wr_strb[0];

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // rate and enable land in the same edge, so a combined write works
  // bit 4 is held at zero whatever is written
  assign nxt_ctrl = wr_take ? (wr_data[7:0] & CTRL_WR_MASK) : ctrl_ff; // [RULE_05] [RULE_07]

  // read channel
  wire           ar_hs   = s_axi_arvalid & s_axi_arready;
  wire           rd_hit  = (s_axi_araddr[AW-1:2] == CTRL_ADDR[AW-1:2]);

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // tap decode
  wire [2:0]     tick_code = ctrl_ff[TICK_RATE_HI:TICK_RATE_LO];
  wire [1:0]     buz_code  = ctrl_ff[BUZ_RATE_HI:BUZ_RATE_LO];
  wire [W-1:0]   tick_msk  = tap_mask(TICK_EXP[tick_code], prescale_double_sel); // [RULE_06]
  wire [W-1:0]   buz_msk   = tap_mask(BUZ_EXP[buz_code], prescale_double_sel);   // [RULE_11]
  // tap is the mask's top bit; it falls at the edge where all masked bits are ones
  wire           tick_fall = &(count | ~tick_msk);
  wire [W-1:0]   buz_sel   = buz_msk & ~(buz_msk >> 1);
  wire           buz_tap   = |(count & buz_sel);
  // irq aligned to the edge where the tap falls; first one may come early
  wire           nxt_irq   = ctrl_ff[TICK_EN_BIT] & tick_fall; // [RULE_01] [RULE_14] [RULE_02]
  // half duty square wave straight from the tap
  wire           nxt_buz   = ctrl_ff[BUZ_EN_BIT] ? buz_tap : BUZ_IDLE_LEVEL; // [RULE_09] [RULE_10]

  assign periodic_tick_irq = irq_ff;
  assign buzzer_out_pin    = buz_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
      irq_ff  <= 1'b0;
      buz_ff  <= BUZ_IDLE_LEVEL;
    end else begin
      ctrl_ff <= nxt_ctrl;
      irq_ff  <= nxt_irq;
      buz_ff  <= nxt_buz;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      aw_got_ff <= aw_have & ~do_wr;
      w_got_ff  <= w_have & ~do_wr;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      bvalid_ff <= do_wr | (bvalid_ff & ~s_axi_bready);
      if (do_wr) begin
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
    end else begin
      rvalid_ff <= ar_hs | (rvalid_ff & ~s_axi_rready);
      if (ar_hs) begin
        rdata_ff <= rd_hit ? {24'h0, ctrl_ff} : 32'h0;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule : tbd_top

// ===== tbd_pkg.sv
// Function
// [RULE_01] setting tick enable raises the tick irq at the next falling tap edge
// [RULE_02] the shared prescaler is never cleared by enabling the tick
// [RULE_03] software changes tick rate only while tick enable is zero
// [RULE_04] software keeps tick rate unchanged in the write clearing tick enable
// [RULE_05] one write may set tick rate and tick enable together
// [RULE_06] tick rate codes select divide by 2^23..2^9, doubled when prescale doubling
// [RULE_07] control byte: buzzer enable, buzzer rate, zero bit, tick enable, tick rate
// [RULE_08] software always writes zero into bit 4 of the control byte
// [RULE_09] buzzer enabled drives a half duty square wave at the selected rate
// [RULE_10] buzzer enable bit one turns the output on, zero turns it off
// [RULE_11] buzzer rate codes select divide by 2^13..2^10, doubled when doubling
// [RULE_12] software changes buzzer rate only while buzzer output is disabled
// [RULE_13] software sets port latch then port direction before using the buzzer pin
// [RULE_14] while enabled, one tick irq pulse on every falling edge of the tap
// [RULE_15] prescale doubling input shifts both tap selections by one stage
package tbd_pkg;
  localparam int          PRESC_W        = 24;
  localparam logic [7:0]  CTRL_INDEX     = 8'h36;
  localparam logic [11:0] CTRL_ADDR      = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          BUZ_EN_BIT     = 7;
  localparam int          BUZ_RATE_HI    = 6;
  localparam int          BUZ_RATE_LO    = 5;
  localparam int          ZERO_BIT       = 4;
  localparam int          TICK_EN_BIT    = 3;
  localparam int          TICK_RATE_HI   = 2;
  localparam int          TICK_RATE_LO   = 0;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'hef;
  // divisor exponents for tick rate codes 0..7 and buzzer codes 0..3
  localparam logic [4:0]  TICK_EXP [8]   = '{5'd23, 5'd21, 5'd16, 5'd14,
                                             5'd13, 5'd12, 5'd11, 5'd9};
  localparam logic [4:0]  BUZ_EXP [4]    = '{5'd13, 5'd12, 5'd11, 5'd10};
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic        BUZ_IDLE_LEVEL = 1'b1;
endpackage : tbd_pkg

// ===== tbd_prescaler.sv
`timescale 1ns/10ps
module tbd_prescaler #(
  parameter int W = tbd_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // divider stages
  output logic [W-1:0]      count
);
  import tbd_pkg::*;

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  // free running; nothing in software clears it
  assign nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1}; // [RULE_02]
  assign count     = count_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule : tbd_prescaler

// ===== tbd_properties.sv
`timescale 1ns/10ps
module tbd_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // events and pins
  input wire logic        periodic_tick_irq,
  input wire logic        buzzer_out_pin
);
  // low stages only: no tap is faster than 2^9
  logic [8:0] cnt_ff;
  always_ff @(posedge aclk) cnt_ff <= aresetn ? cnt_ff + 9'h1 : 9'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  bbusy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  blat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("no write response");
  rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved");
  rlat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  rfmt_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4])
    else $error("read format");
  irq_pulse_a: assert property (periodic_tick_irq |=> !periodic_tick_irq [*8])
    else $error("tick pulse too long");
  irq_tap_a: assert property (periodic_tick_irq |-> cnt_ff == 9'h0)
    else $error("tick off tap edge");
  cover property (periodic_tick_irq);
  cover property ($fell(buzzer_out_pin));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : tbd_properties

// ===== tbd_partner.sv
`timescale 1ns/10ps
module tbd_partner (
  // watched events and pins
  input  wire logic aclk,
  input  wire logic irq,
  input  wire logic pin,
  // measured counts and spans
  output int        irq_cnt,
  output int        gap,
  output int        hi,
  output int        lo
);
  // listens only; first span after a change of rate is partial
  int   run, span;
  logic pin_q = 1'b1;
  always @(posedge aclk) begin
    run <= irq ? 0 : run + 1;
    span <= (pin !== pin_q) ? 0 : span + 1;
    pin_q <= pin;
    if (irq) begin
      irq_cnt <= irq_cnt + 1;
      gap <= run + 1;
    end
    if (pin !== pin_q && pin_q) hi <= span + 1;
    if (pin !== pin_q && !pin_q) lo <= span + 1;
  end
endmodule : tbd_partner

// ===== tbd_bench.sv
`timescale 1ns/10ps
module tbd_bench;
  import tbd_pkg::*;
  logic aclk = 1'b0, rstn = 1'b0, dbl = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, ta, tw;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hf;
  logic [1:0] rs;
  wire logic awr, wr, bv, arr, rv, irq, pin;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdat;
  int fails = 0, tests_run = 0, irqs, gap, hi, lo;
  tbd_top u_dut (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .prescale_double_sel(dbl), .periodic_tick_irq(irq), .buzzer_out_pin(pin));
  tbd_partner u_far (.aclk(aclk), .irq(irq), .pin(pin), .irq_cnt(irqs), .gap(gap), .hi(hi),
    .lo(lo));
  initial forever #50 aclk = ~aclk;
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task stop;
    fails++;
    print_verdict();
  endtask : stop
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // readies judged at the falling edge, so the taking edge is known
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
    awa <= a;
    ara <= a;
    wd <= {24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (!(awv || wv || arv)) break;
      ta = (awv && awr) || (arv && arr);
      tw = wv && wr;
      @(posedge aclk);
      if (ta) {awv, arv} <= 2'h0;
      if (tw) wv <= 1'b0;
    end
    for (n = n; n < 99 && !(bv || rv); n++) @(negedge aclk);
    if (n >= 99) stop();
    rs = w ? br : rr;
    rd = rdat;
    @(posedge aclk);
    {bry, rry} <= 2'h0;
  endtask : bus
  task wait_irq(input int lim);
    int n, s;
    s = irqs;
    for (n = 0; n < lim && irqs == s; n++) @(negedge aclk);
    if (irqs == s) stop();
  endtask : wait_irq
  task t_regs;
    bus(0, CTRL_ADDR, 8'h0);
    chk("ctrl reset", CTRL_RESET, rd);
    chk("rresp ok", RESP_OKAY, rs);
    chk("pin reset", BUZ_IDLE_LEVEL, pin);
    bus(1, CTRL_ADDR, 8'he7);
    chk("bresp ok", RESP_OKAY, rs);
    bus(0, CTRL_ADDR, 8'h0);
    chk("ctrl", 32'he7, rd);
    bus(1, 12'h0, 8'h0);
    chk("bresp", RESP_SLVERR, rs);
    bus(0, 12'h0, 8'h0);
    chk("rresp", RESP_SLVERR, rs);
    bus(1, CTRL_ADDR, 8'h67);
  endtask : t_regs
  task t_tick(input logic [2:0] c, input logic d);
    int p, s;
    p = 1 << (TICK_EXP[c] + d);
    @(posedge aclk);
    dbl <= d;
    bus(1, CTRL_ADDR, {5'h01, c});
    wait_irq(p + 9);
    wait_irq(p + 9);
    chk("tick period", p, gap);
    bus(1, CTRL_ADDR, {5'h00, c});
    repeat (2) @(posedge aclk);
    s = irqs;
    repeat (p) @(posedge aclk);
    chk("tick off", s, irqs);
  endtask : t_tick
  task t_buz(input logic [1:0] c, input logic d);
    int p;
    p = 1 << (BUZ_EXP[c] + d);
    @(posedge aclk);
    dbl <= d;
    bus(1, CTRL_ADDR, {1'b1, c, 5'h0});
    repeat (3 * p) @(negedge aclk);
    chk("buzzer high", p / 2, hi);
    chk("buzzer low", p / 2, lo);
    bus(1, CTRL_ADDR, {1'b0, c, 5'h0});
    repeat (2) @(negedge aclk);
    chk("buzzer off", BUZ_IDLE_LEVEL, pin);
  endtask : t_buz
  initial begin
    repeat (4) @(posedge aclk);
    rstn <= 1'b1;
    t_regs();
    for (int i = 5; i < 8; i++) t_tick(3'(i), 1'b0);
    t_tick(3'h7, 1'b1);
    for (int i = 0; i < 4; i++) t_buz(2'(i), 1'b0);
    t_buz(2'h3, 1'b1);
    print_verdict();
  end
endmodule : tbd_bench

bind tbd_top tbd_properties u_chk (
  .aclk              (aclk),
  .aresetn           (aresetn),
  .s_axi_awvalid     (s_axi_awvalid),
  .s_axi_awready     (s_axi_awready),
  .s_axi_wvalid      (s_axi_wvalid),
  .s_axi_wready      (s_axi_wready),
  .s_axi_bvalid      (s_axi_bvalid),
  .s_axi_bready      (s_axi_bready),
  .s_axi_arvalid     (s_axi_arvalid),
  .s_axi_arready     (s_axi_arready),
  .s_axi_rvalid      (s_axi_rvalid),
  .s_axi_rready      (s_axi_rready),
  .s_axi_rdata       (s_axi_rdata),
  .periodic_tick_irq (periodic_tick_irq),
  .buzzer_out_pin    (buzzer_out_pin)
);
